/* File: core/csf_pkg.sv */
// Package: encodings, register map and timing constants for the state and fault sequencer
package csf_pkg;

    // ------------------------------------------------------------
    // Page selector encoding
    // ------------------------------------------------------------
    // fixed four-bit page codes
    typedef enum logic [3:0] {
        PG_MAIN = 4'h0,
        PG_HOLD = 4'h1,        // Load steering code, never stored
        PG_BITOP = 4'h2,
        PG_EXT = 4'h3,
        PG_IDX_X = 4'h4,
        PG_IDX_Y = 4'h5,
        PG_IDX_X_BITOP = 4'h6,
        PG_IDX_Y_BITOP = 4'h7,
        PG_NMI_ACK = 4'h8,
        PG_INT_SEL = 4'h9,     // Load steering code, never stored
        PG_TRAP_A = 4'hA,
        PG_TRAP_B = 4'hB,
        PG_RSV_C = 4'hC,
        PG_RSV_D = 4'hD,
        PG_INT_A = 4'hE,
        PG_INT_B = 4'hF
    } csf_page_t;

    // ------------------------------------------------------------
    // Machine cycle encoding
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        MC_FETCH_1 = 6'h01,
        MC_DELAY = 6'h02,
        MC_FETCH_2 = 6'h04,
        MC_OPERAND_1 = 6'h07,
        MC_READ_1 = 6'h08,
        MC_READ_2 = 6'h0B,
        MC_OPERAND_2 = 6'h0D,
        MC_IOP_1 = 6'h0E,
        MC_WRITE_1 = 6'h15,
        MC_WRITE_2 = 6'h16,
        MC_FETCH_3 = 6'h18,
        MC_FIOP_3 = 6'h19,
        MC_FIOP_2 = 6'h1A,
        MC_FIOP_1 = 6'h1B,
        MC_RESTART = 6'h1C,
        MC_IOP_10 = 6'h1D,
        MC_IOP_9 = 6'h20,
        MC_IOP_8 = 6'h21,
        MC_IOP_7 = 6'h22,
        MC_IOP_6 = 6'h23,
        MC_IOP_5 = 6'h24,
        MC_IOP_4 = 6'h25,
        MC_IOP_3 = 6'h26,
        MC_IOP_2 = 6'h27,
        MC_SIOP_5 = 6'h29,
        MC_SIOP_4 = 6'h2A,
        MC_SIOP_3 = 6'h2B,
        MC_SIOP_2 = 6'h2C,
        MC_SIOP_1 = 6'h2D,
        MC_TRAP_ACK = 6'h30,
        MC_INT_ACK = 6'h38,
        MC_NMI_ACK = 6'h39,
        MC_FAULT = 6'h3A,
        MC_HALT = 6'h3E,
        MC_SLEEP = 6'h3F
    } csf_mach_t;

    // ------------------------------------------------------------
    // Clock cycle tracker, Gray along T1-T2-T3 and release path
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        TS_RESET = 3'h0,
        TS_T1 = 3'h1,
        TS_T2 = 3'h3,
        TS_T3 = 3'h2,
        TS_WAIT = 3'h6,
        TS_T4 = 3'h7,
        TS_REL = 3'h5,
        TS_REL_LAST = 3'h4
    } csf_tstate_t;

    // ------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ------------------------------------------------------------
    localparam logic [3:0] ADR_CTRL = 4'h0;
    localparam logic [3:0] ADR_PAGE = 4'h4;
    localparam logic [3:0] ADR_STATUS = 4'h8;
    localparam logic [3:0] ADR_FAULTS = 4'hC;
    localparam int CTRL_FORCE_DEF_BIT = 0;
    localparam int CTRL_PIN_LOAD_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h2;
    localparam int ST_PAGE_LSB = 0;
    localparam int ST_TS_LSB = 4;
    localparam int ST_MACH_LSB = 8;
    localparam int ST_FAULT_BIT = 16;
    localparam int ST_FETCH_BIT = 17;
    localparam int ST_INTACK_BIT = 18;
    localparam int ST_OVERRUN_BIT = 19;
    localparam int ST_RECOV_LSB = 24;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int RECOVER_MAX_CYC = 19;  // Longest instruction, in clocks
    localparam logic [4:0] RECOV_LIMIT = 5'(RECOVER_MAX_CYC);
    localparam logic [4:0] RECOV_SAT = 5'h1F;

endpackage : csf_pkg

/* File: core/csf_page_if.sv */
// Interface: page selector load path and illegal-code indication
`timescale 1ns/1ns
interface csf_page_if;
    logic load_en;
    logic [3:0] load_val;
    csf_pkg::csf_page_t page;
    logic illegal;

    modport ctl (output load_en, output load_val, input page, input illegal);
    modport pg (input load_en, input load_val, output page, output illegal);
endinterface : csf_page_if

/* File: core/csf_page_reg.sv */
// Module: four-bit page selector with steering codes and reserved-code detector
`timescale 1ns/1ns
module csf_page_reg (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Page path
    csf_page_if.pg pif
);
    import csf_pkg::*;

    // ------------------------------------------------------------
    // Page storage
    // ------------------------------------------------------------
    // reset to main
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pif.page <= PG_MAIN;
        end else if (pif.load_en) begin
            case (pif.load_val)
                PG_HOLD: pif.page <= pif.page;
                PG_INT_SEL: pif.page <= PG_INT_A;
                // Raw load lets an upset-like value be injected for test
                default: pif.page <= csf_page_t'(pif.load_val);
            endcase
        end
    end

    // ------------------------------------------------------------
    // Illegal-code decode
    // ------------------------------------------------------------
    // reserved code decode
    // Steering codes are illegal as a stored value too
    always_comb begin
        case (pif.page)
            PG_HOLD, PG_INT_SEL, PG_RSV_C, PG_RSV_D: pif.illegal = 1'b1;
            default: pif.illegal = 1'b0;
        endcase
    end

endmodule : csf_page_reg

/* File: core/csf_seq_top.sv */
// Module: clock-cycle tracker, machine-cycle sequencer and fault reporting
//
// Local design decisions: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
module csf_seq_top (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Control section inputs
    input wire logic bus_req,
    input wire logic wait_req,
    input wire logic int_take,
    input wire logic int_pending,
    input wire logic [5:0] seq_next,
    input wire logic page_load,
    input wire logic [3:0] page_next,
    // State and fault outputs
    output logic fault_out_n,
    output csf_pkg::csf_mach_t mach_state,
    output csf_pkg::csf_tstate_t t_state,
    output logic bus_ack,
    output logic fetch_after_release_bit,
    output logic intack_after_release_bit
);
    import csf_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // default next state table
    function automatic csf_mach_t default_next(input csf_mach_t cur);
        case (cur)
            MC_FETCH_1, MC_DELAY: default_next = MC_OPERAND_1;
            MC_FETCH_2: default_next = MC_TRAP_ACK;
            MC_OPERAND_1: default_next = MC_OPERAND_2;
            MC_READ_1: default_next = MC_READ_2;
            MC_WRITE_1: default_next = MC_WRITE_2;
            MC_FETCH_3: default_next = MC_READ_2;
            MC_READ_2, MC_OPERAND_2, MC_IOP_1, MC_WRITE_2: default_next = MC_FETCH_1;
            MC_FIOP_3: default_next = MC_FIOP_2;
            MC_FIOP_2: default_next = MC_FIOP_1;
            MC_FIOP_1, MC_RESTART, MC_FAULT: default_next = MC_FETCH_1;
            MC_IOP_10: default_next = MC_IOP_9;
            MC_IOP_9: default_next = MC_IOP_8;
            MC_IOP_8: default_next = MC_IOP_7;
            MC_IOP_7: default_next = MC_IOP_6;
            MC_IOP_6: default_next = MC_IOP_5;
            MC_IOP_5: default_next = MC_IOP_4;
            MC_IOP_4: default_next = MC_IOP_3;
            MC_IOP_3: default_next = MC_IOP_2;
            MC_IOP_2: default_next = MC_IOP_1;
            MC_SIOP_5: default_next = MC_SIOP_4;
            MC_SIOP_4: default_next = MC_SIOP_3;
            MC_SIOP_3: default_next = MC_SIOP_2;
            MC_SIOP_2: default_next = MC_SIOP_1;
            MC_SIOP_1: default_next = MC_WRITE_2;
            MC_TRAP_ACK: default_next = MC_SIOP_5;
            MC_NMI_ACK: default_next = MC_SIOP_2;
            MC_INT_ACK: default_next = MC_OPERAND_1;
            MC_HALT: default_next = MC_HALT;
            MC_SLEEP: default_next = MC_SLEEP;
            default: default_next = MC_FAULT;
        endcase
    endfunction : default_next

    // Legal machine code: anything the table does not send to fault itself
    function automatic logic mach_legal(input csf_mach_t cur);
        mach_legal = (cur == MC_FAULT) || (cur == MC_READ_2) || (cur == MC_OPERAND_2)
            || (cur == MC_IOP_1) || (cur == MC_WRITE_2) || (cur == MC_FETCH_1)
            || (default_next(cur) != MC_FAULT);
    endfunction : mach_legal

    // Single-clock machine cycles run as T4 only
    function automatic logic single_clock(input csf_mach_t cur);
        case (cur)
            MC_DELAY, MC_RESTART, MC_FAULT, MC_HALT, MC_SLEEP: single_clock = 1'b1;
            MC_IOP_1, MC_IOP_2, MC_IOP_3, MC_IOP_4, MC_IOP_5: single_clock = 1'b1;
            MC_IOP_6, MC_IOP_7, MC_IOP_8, MC_IOP_9, MC_IOP_10: single_clock = 1'b1;
            MC_SIOP_1, MC_SIOP_2, MC_SIOP_3, MC_SIOP_4, MC_SIOP_5: single_clock = 1'b1;
            MC_FIOP_1, MC_FIOP_2, MC_FIOP_3: single_clock = 1'b1;
            default: single_clock = 1'b0;
        endcase
    endfunction : single_clock

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    csf_page_if pif ();
    logic [1:0] ctrl;
    logic [15:0] fault_count;
    logic [4:0] recov_cnt;
    logic overrun;
    csf_mach_t pending;
    csf_mach_t next_mach;
    csf_tstate_t next_t_state;
    logic cycle_end;
    logic mach_illegal;
    logic use_default;
    logic wb_req;
    logic wb_wr;
    logic sw_page_wr;

    // ------------------------------------------------------------
    // Page selector
    // ------------------------------------------------------------
    csf_page_reg u_page (
        .clk(clk),
        .sys_rst(sys_rst),
        .pif(pif)
    );

    // Pin loads happen at cycle end; a software write wins the same clock
    assign sw_page_wr = wb_wr && (wb_adr_i == ADR_PAGE) && wb_sel_i[0];
    assign pif.load_en = sw_page_wr || (ctrl[CTRL_PIN_LOAD_BIT] && page_load && cycle_end);
    assign pif.load_val = sw_page_wr ? wb_dat_i[3:0] : page_next;

    // fault output low
    // An illegal machine code also drives the fault output low
    assign fault_out_n = ~(pif.illegal || mach_illegal);

    // ------------------------------------------------------------
    // Next machine state
    // ------------------------------------------------------------
    assign mach_illegal = ~mach_legal(mach_state);
    assign cycle_end = (t_state == TS_T3) || (t_state == TS_T4);
    assign use_default = pif.illegal || mach_illegal || ctrl[CTRL_FORCE_DEF_BIT];

    always_comb begin
        next_mach = use_default ? default_next(mach_state) : csf_mach_t'(seq_next);
        case (mach_state)
            MC_HALT, MC_SLEEP: next_mach = int_take ? MC_INT_ACK : mach_state;
            MC_FAULT: next_mach = int_pending ? MC_INT_ACK : MC_FETCH_1;
            default: ;
        endcase
    end

    // ------------------------------------------------------------
    // Clock cycle tracker
    // ------------------------------------------------------------
    // full decode every clock
    always_comb begin
        case (t_state)
            TS_RESET: next_t_state = single_clock(mach_state) ? TS_T4 : TS_T1;
            TS_T1: next_t_state = TS_T2;
            TS_T2, TS_WAIT: next_t_state = wait_req ? TS_WAIT : TS_T3;
            TS_T3, TS_T4: begin
                if (bus_req) begin
                    next_t_state = TS_REL;
                end else begin
                    next_t_state = single_clock(next_mach) ? TS_T4 : TS_T1;
                end
            end
            TS_REL: next_t_state = bus_req ? TS_REL : TS_REL_LAST;
            TS_REL_LAST: next_t_state = single_clock(pending) ? TS_T4 : TS_T1;
            default: next_t_state = TS_RESET;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            t_state <= TS_RESET;
        end else begin
            t_state <= next_t_state;
        end
    end

    assign bus_ack = (t_state == TS_REL) || (t_state == TS_REL_LAST);

    // ------------------------------------------------------------
    // Machine cycle and bus release memory
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mach_state <= MC_FETCH_1;
            pending <= MC_FETCH_1;
            fetch_after_release_bit <= 1'b0;
            intack_after_release_bit <= 1'b0;
        end else if (cycle_end && bus_req) begin
            pending <= next_mach;
            fetch_after_release_bit <= (next_mach == MC_FETCH_1);
            intack_after_release_bit <= (next_mach == MC_INT_ACK);
        end else if (cycle_end) begin
            mach_state <= next_mach;
        end else if (t_state == TS_REL_LAST) begin
            if (fetch_after_release_bit) begin
                mach_state <= MC_FETCH_1;
            end else if (intack_after_release_bit) begin
                mach_state <= MC_INT_ACK;
            end else begin
                mach_state <= pending;
            end
        end
    end

    // ------------------------------------------------------------
    // Recovery watch
    // ------------------------------------------------------------
    // recovery bound of nineteen
    // Counts clocks from an illegal page until the next fetch begins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            recov_cnt <= 5'h0;
            overrun <= 1'b0;
        end else begin
            if (mach_state == MC_FETCH_1) begin
                recov_cnt <= 5'h0;
            end else if (pif.illegal || (recov_cnt != 5'h0)) begin
                recov_cnt <= (recov_cnt == RECOV_SAT) ? RECOV_SAT : recov_cnt + 5'h1;
            end
            if (recov_cnt > RECOV_LIMIT) begin
                overrun <= 1'b1;
            end else if (wb_wr && (wb_adr_i == ADR_FAULTS)) begin
                overrun <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr = wb_req && wb_we_i;

    // One-clock answer, ack drops the cycle after
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    // Control bits
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl <= CTRL_RESET;
        end else if (wb_wr && (wb_adr_i == ADR_CTRL) && wb_sel_i[0]) begin
            ctrl <= wb_dat_i[1:0];
        end
    end

    // Fault entry count; a new entry beats the clearing write
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fault_count <= 16'h0;
        end else if ((cycle_end && !bus_req && (next_mach == MC_FAULT)
                      && (mach_state != MC_FAULT))
                     || ((t_state == TS_REL_LAST) && (pending == MC_FAULT))) begin
            if (wb_wr && (wb_adr_i == ADR_FAULTS)) begin
                fault_count <= 16'h1;
            end else begin
                fault_count <= fault_count + 16'h1;
            end
        end else if (wb_wr && (wb_adr_i == ADR_FAULTS)) begin
            fault_count <= 16'h0;
        end
    end

    // Read data, unmapped addresses read zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wb_dat_o <= 32'h0;
        end else if (wb_req && !wb_we_i) begin
            wb_dat_o <= 32'h0;
            case (wb_adr_i)
                ADR_CTRL: wb_dat_o[1:0] <= ctrl;
                ADR_PAGE: wb_dat_o[3:0] <= pif.page;
                ADR_STATUS: begin
                    wb_dat_o[ST_PAGE_LSB +: 4] <= pif.page;
                    wb_dat_o[ST_TS_LSB +: 3] <= t_state;
                    wb_dat_o[ST_MACH_LSB +: 6] <= mach_state;
                    wb_dat_o[ST_FAULT_BIT] <= ~fault_out_n;
                    wb_dat_o[ST_FETCH_BIT] <= fetch_after_release_bit;
                    wb_dat_o[ST_INTACK_BIT] <= intack_after_release_bit;
                    wb_dat_o[ST_OVERRUN_BIT] <= overrun;
                    wb_dat_o[ST_RECOV_LSB +: 5] <= recov_cnt;
                end
                ADR_FAULTS: wb_dat_o[15:0] <= fault_count;
                default: ;
            endcase
        end
    end

endmodule : csf_seq_top

/* File: sim/csf_fault_mon.sv */
// Partner model: external watcher that tallies fault output low cycles
`timescale 1ns/1ns
module csf_fault_mon (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Watched pin and tally
    input wire logic fault_out_n,
    output int low_cycles
);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            low_cycles <= 0;
        end else if (fault_out_n === 1'b0) begin
            low_cycles <= low_cycles + 1;
        end
    end
endmodule : csf_fault_mon

/* File: sim/csf_seq_checker.sv */
// Checker: concurrent properties on the sequencer top ports
`timescale 1ns/1ns
module csf_seq_checker
    import csf_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Bus and control inputs
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic bus_req,
    input wire logic int_take,
    // Watched outputs
    input wire logic fault_out_n,
    input csf_pkg::csf_mach_t mach_state,
    input csf_pkg::csf_tstate_t t_state,
    input wire logic fetch_after_release_bit,
    input wire logic intack_after_release_bit
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // Legal machine code decode, unknown names come back empty
    logic mach_ok;
    always_comb mach_ok = (mach_state.name() != "");

    a_bad_mach_fault: assert property (!mach_ok |-> !fault_out_n)
        else $error("fault output high on unused machine state");
    a_tstate_live: assert property (!$past(sys_rst) |-> t_state != TS_RESET)
        else $error("tracker shows reset code outside reset");
    a_mach_hold: assert property (!(t_state inside {TS_T3, TS_T4, TS_REL_LAST})
        |=> $stable(mach_state))
        else $error("machine state moved before cycle end");
    a_fault_once: assert property (mach_state == MC_FAULT && t_state == TS_T4 && !bus_req
        |=> mach_state != MC_FAULT)
        else $error("fault state held beyond one clock");
    a_park_stay: assert property (mach_state inside {MC_HALT, MC_SLEEP} && t_state == TS_T4
        && !int_take |=> $stable(mach_state))
        else $error("halt or sleep left without interrupt");
    a_rel_last: assert property (t_state == TS_REL && !bus_req |=> t_state == TS_REL_LAST)
        else $error("release did not pass through its last clock");
    a_rel_fetch: assert property (t_state == TS_REL_LAST && fetch_after_release_bit
        |=> mach_state == MC_FETCH_1)
        else $error("release exit ignored fetch bit");
    a_rel_intack: assert property (t_state == TS_REL_LAST && intack_after_release_bit
        && !fetch_after_release_bit |=> mach_state == MC_INT_ACK)
        else $error("release exit ignored acknowledge bit");
    a_def_chain: assert property (mach_state == MC_IOP_10 && !fault_out_n && t_state == TS_T4
        && !bus_req |=> mach_state == MC_IOP_9)
        else $error("internal chain left default order");
    a_wb_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus acknowledge not a single pulse");
endmodule : csf_seq_checker

bind csf_seq_top csf_seq_checker chk_u (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .bus_req(bus_req), .int_take(int_take),
    .fault_out_n(fault_out_n), .mach_state(mach_state), .t_state(t_state),
    .fetch_after_release_bit(fetch_after_release_bit),
    .intack_after_release_bit(intack_after_release_bit));

/* File: sim/cpu_state_fault_sequencing_test.sv */
// Testbench: randomised sequencer run against a behavioural reference
`timescale 1ns/1ns
`define CHK(nm, got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            miscompares++; \
            $display("MISMATCH %s exp %0h got %0h", nm, exp, got); \
        end \
    end
module cpu_state_fault_sequencing_test;
    import csf_pkg::*;
    logic clk, sys_rst, wb_cyc, wb_stb, wb_we, wb_ack, bus_req, wait_req, int_take;
    logic int_pending, page_load, fault_out_n, bus_ack, fab, iab, valid, run, br, sw, fn, e_rel;
    logic [3:0] wb_adr, wb_sel, page_next, m_page;
    logic [31:0] wb_dat, wb_q, q;
    logic [5:0] seq_next;
    logic [1:0] m_ctrl;
    logic [5:0] picks[$];
    csf_mach_t mach_state, e_mach, rel_pend;
    csf_tstate_t t_state;
    int seed = 52424;
    int cyc_cnt, exp_low, low_cycles, miscompares, total_checks, n_flt;
    // Default successor table, fault handled apart
    csf_mach_t dflt [csf_mach_t] = '{MC_FETCH_1: MC_OPERAND_1, MC_DELAY: MC_OPERAND_1,
        MC_FETCH_2: MC_TRAP_ACK, MC_OPERAND_1: MC_OPERAND_2, MC_READ_1: MC_READ_2,
        MC_READ_2: MC_FETCH_1, MC_OPERAND_2: MC_FETCH_1, MC_IOP_1: MC_FETCH_1,
        MC_WRITE_1: MC_WRITE_2, MC_WRITE_2: MC_FETCH_1, MC_FETCH_3: MC_READ_2,
        MC_FIOP_3: MC_FIOP_2, MC_FIOP_2: MC_FIOP_1, MC_FIOP_1: MC_FETCH_1, MC_RESTART: MC_FETCH_1,
        MC_IOP_10: MC_IOP_9, MC_IOP_9: MC_IOP_8, MC_IOP_8: MC_IOP_7, MC_IOP_7: MC_IOP_6,
        MC_IOP_6: MC_IOP_5, MC_IOP_5: MC_IOP_4, MC_IOP_4: MC_IOP_3, MC_IOP_3: MC_IOP_2,
        MC_IOP_2: MC_IOP_1, MC_SIOP_5: MC_SIOP_4, MC_SIOP_4: MC_SIOP_3, MC_SIOP_3: MC_SIOP_2,
        MC_SIOP_2: MC_SIOP_1, MC_SIOP_1: MC_WRITE_2, MC_TRAP_ACK: MC_SIOP_5,
        MC_INT_ACK: MC_OPERAND_1, MC_NMI_ACK: MC_SIOP_2, MC_FAULT: MC_FETCH_1,
        MC_HALT: MC_HALT, MC_SLEEP: MC_SLEEP};

    csf_seq_top dut_u (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_q), .wb_ack_o(wb_ack), .bus_req(bus_req), .wait_req(wait_req),
        .int_take(int_take), .int_pending(int_pending), .seq_next(seq_next),
        .page_load(page_load), .page_next(page_next), .fault_out_n(fault_out_n),
        .mach_state(mach_state), .t_state(t_state), .bus_ack(bus_ack),
        .fetch_after_release_bit(fab), .intack_after_release_bit(iab));
    csf_fault_mon mon_u (.clk(clk), .sys_rst(sys_rst), .fault_out_n(fault_out_n),
        .low_cycles(low_cycles));

    function automatic logic [3:0] steer(logic [3:0] v, logic [3:0] cur);
        if (v == 4'h1) return cur;
        if (v == 4'h9) return 4'hE;
        return v;
    endfunction : steer

    function automatic csf_mach_t nxt(csf_mach_t m);
        if (m inside {MC_HALT, MC_SLEEP}) return int_take ? MC_INT_ACK : m;
        if (m == MC_FAULT) return int_pending ? MC_INT_ACK : MC_FETCH_1;
        if (!dflt.exists(m)) return MC_FAULT;
        if (m_page inside {4'h1, 4'h9, 4'hC, 4'hD} || m_ctrl[0]) return dflt[m];
        return csf_mach_t'(seq_next);
    endfunction : nxt

    // Single classic bus cycle, waits for acknowledge under a bound
    task automatic wb_io(input logic w, input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} <= {2'b11, w, a, s, d};
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (n >= 50) miscompares++;
        r = wb_q;
        {wb_cyc, wb_stb, wb_we} <= 3'b000;
    endtask : wb_io

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 10000) begin
            miscompares++;
            test_done();
        end
    end

    // Random control-section stimulus, page loads kept off release entry
    always @(posedge clk) begin
        if (run) begin
            br = ($random(seed) & 15) == 0;
            bus_req <= br;
            wait_req <= ($random(seed) & 3) == 0;
            int_take <= 1'($random(seed));
            int_pending <= 1'($random(seed));
            seq_next <= picks[$unsigned($random(seed)) % picks.size()];
            page_load <= !br && (($random(seed) & 7) == 0);
            page_next <= 4'($random(seed));
        end
    end

    // Reference: machine, release and page updates at each edge
    always @(posedge clk) begin
        valid <= !sys_rst;
        sw = wb_cyc && wb_stb && !wb_ack && wb_we && wb_sel[0];
        if (sys_rst) begin
            m_page = 4'h0;
            m_ctrl = CTRL_RESET;
            e_mach = MC_FETCH_1;
        end else begin
            if (t_state == TS_REL_LAST) begin
                e_mach = rel_pend;
            end else if (t_state inside {TS_T3, TS_T4}) begin
                rel_pend = nxt(mach_state);
                e_mach = bus_req ? mach_state : rel_pend;
            end else begin
                e_mach = mach_state;
            end
            // Fault entries, and release state one edge ahead
            if (e_mach == MC_FAULT && mach_state != MC_FAULT) n_flt++;
            e_rel = (t_state inside {TS_T3, TS_T4}) ? bus_req : (t_state == TS_REL);
            if (sw && wb_adr == ADR_PAGE) begin
                m_page = steer(wb_dat[3:0], m_page);
            end else if (page_load && m_ctrl[1] && t_state inside {TS_T3, TS_T4}) begin
                m_page = steer(page_next, m_page);
            end
            if (sw && wb_adr == ADR_CTRL) m_ctrl = wb_dat[1:0];
        end
    end

    // Compare settled outputs mid-cycle
    always @(negedge clk) begin
        if (valid) begin
            fn = !(m_page inside {4'h1, 4'h9, 4'hC, 4'hD} || !dflt.exists(mach_state));
            if (!fn) exp_low++;
            `CHK("mach", mach_state, e_mach)
            `CHK("fault_n", fault_out_n, fn)
            `CHK("bus_ack", bus_ack, e_rel)
            if (t_state inside {TS_REL, TS_REL_LAST}) begin
                `CHK("fetch_bit", fab, rel_pend == MC_FETCH_1)
                `CHK("intack_bit", iab, rel_pend == MC_INT_ACK)
            end
        end
    end

    initial begin
        {wb_cyc, wb_stb, wb_we, bus_req, wait_req, int_take, int_pending, page_load} = '0;
        {wb_adr, wb_sel, wb_dat, page_next, seq_next} = {8'h0F, 36'h0, 6'h01};
        {run, sys_rst} = 2'b01;
        foreach (dflt[k]) picks.push_back(k);
        picks.push_back(6'h00);
        picks.push_back(6'h3C);
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        wb_io(1'b0, ADR_CTRL, 32'h0, 4'hF, q);
        `CHK("ctrl", q, 32'h2)
        wb_io(1'b0, ADR_PAGE, 32'h0, 4'hF, q);
        `CHK("page", q, 32'h0)
        wb_io(1'b0, 4'h2, 32'h0, 4'hF, q);
        `CHK("hole", q, 32'h0)
        // Every page code, pins off, then a masked write
        wb_io(1'b1, ADR_CTRL, 32'h0, 4'hF, q);
        for (int c = 0; c < 17; c++) begin
            wb_io(1'b1, ADR_PAGE, 32'(c & 15), (c == 16) ? 4'h0 : 4'hF, q);
            wb_io(1'b0, ADR_PAGE, 32'h0, 4'hF, q);
            `CHK("page", q[3:0], m_page)
        end
        run = 1'b1;
        for (int i = 0; i < 15; i++) begin
            repeat (200) @(posedge clk);
            wb_io(1'b1, ADR_CTRL, 32'($random(seed)), 4'hF, q);
            wb_io(1'b1, ADR_PAGE, 32'($random(seed) & 15), 4'hF, q);
        end
        @(negedge clk);
        run = 1'b0;
        @(posedge clk);
        {bus_req, wait_req, int_take, page_load, seq_next} <= {4'h0, 6'h01};
        wb_io(1'b1, ADR_CTRL, 32'h0, 4'hF, q);
        wb_io(1'b1, ADR_PAGE, 32'h0, 4'hF, q);
        repeat (40) @(posedge clk);
        wb_io(1'b0, ADR_FAULTS, 32'h0, 4'hF, q);
        `CHK("faults", q, 32'(n_flt))
        `CHK("low_cycles", low_cycles, exp_low)
        test_done();
    end
endmodule : cpu_state_fault_sequencing_test
